// ---- hw/sck_ctrl_regs.svh ----
// Register indices, field positions, reset values and timing counts for the synthesizer control block.
// Assumes a 32-bit AXI4-Lite bus where byte address = 4 * register index.
`ifndef SCK_CTRL_REGS_SVH
`define SCK_CTRL_REGS_SVH

`define SCK_IDX_FEEDBACK   16'hf000
`define SCK_IDX_PRESCALE   16'hf001
`define SCK_IDX_SOURCE     16'hf002
`define SCK_IDX_ENABLE     16'hf003
`define SCK_IDX_LOCK       16'hf004
`define SCK_IDX_REFOUT     16'hf005
`define SCK_IDX_IRQ_STAT   16'hf010
`define SCK_IDX_IRQ_MASK   16'hf011

`define SCK_RST_FEEDBACK   7'h60
`define SCK_RST_PRESCALE   2'h0
`define SCK_RST_SOURCE     1'h0
`define SCK_RST_ENABLE     1'h0
`define SCK_RST_REFOUT     3'h0

`define SCK_REFOUT_EN_BIT  0
`define SCK_REFOUT_RATE_LO 1
`define SCK_REFOUT_RATE_HI 2
`define SCK_IRQ_LOCKED_BIT 0
`define SCK_IRQ_LOST_BIT   1

`define SCK_LOCK_EDGES     64
`define SCK_GAP_NS         2000
`define SCK_CLK_NS         10
`define SCK_GAP_CYC        (`SCK_GAP_NS / `SCK_CLK_NS)

`endif

// ---- hw/sck_pkg.sv ----
// Types shared by the synthesizer control block.
// Assumes the constants header supplies all numbers.
package sck_pkg;

    typedef enum logic [1:0] {
        SCK_IDLE    = 2'b00,
        SCK_ACQUIRE = 2'b01,
        SCK_LOCKED  = 2'b10
    } sck_state_t;

    typedef struct packed {
        logic [6:0] feedback;
        logic [1:0] prescale;
        logic       source;
        logic [1:0] out_rate;
        logic       out_en;
    } sck_settings_t;

endpackage

// ---- hw/sck_ctrl_top.sv ----
// Synthesizer enable, lock flag and reference clock output control with an AXI4-Lite register slave.
// Assumes master_clock_pin_in is asynchronous and far slower than sys_clk_in.
`timescale 1ns/1ps
`default_nettype none
`include "sck_ctrl_regs.svh"

module sck_ctrl_top #(
    parameter int ADDR_W     = 18,
    parameter int LOCK_EDGES = `SCK_LOCK_EDGES,
    parameter int GAP_CYC    = `SCK_GAP_CYC
) (
    input  wire logic                  sys_clk_in,
    input  wire logic                  resetn_in,
    input  wire logic [ADDR_W-1:0]     s_axi_awaddr_in,
    input  wire logic                  s_axi_awvalid_in,
    output var  logic                  s_axi_awready_out,
    input  wire logic [31:0]           s_axi_wdata_in,
    input  wire logic [3:0]            s_axi_wstrb_in,
    input  wire logic                  s_axi_wvalid_in,
    output var  logic                  s_axi_wready_out,
    output var  logic [1:0]            s_axi_bresp_out,
    output var  logic                  s_axi_bvalid_out,
    input  wire logic                  s_axi_bready_in,
    input  wire logic [ADDR_W-1:0]     s_axi_araddr_in,
    input  wire logic                  s_axi_arvalid_in,
    output var  logic                  s_axi_arready_out,
    output var  logic [31:0]           s_axi_rdata_out,
    output var  logic [1:0]            s_axi_rresp_out,
    output var  logic                  s_axi_rvalid_out,
    input  wire logic                  s_axi_rready_in,
    input  wire logic                  master_clock_pin_in,
    output var  logic                  ref_output_pin_out,
    output var  logic                  ref_output_pin_oe_out,
    output var  logic                  synth_clock_running_out,
    output var  logic                  core_clock_source_bit_out,
    output var  sck_pkg::sck_settings_t synth_settings_out,
    output var  logic                  irq_out
);
    import sck_pkg::*;

    localparam int IDX_W = ADDR_W - 2;

    function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] strb);
        merge16 = {strb[1] ? new_v[15:8] : old_v[15:8], strb[0] ? new_v[7:0] : old_v[7:0]};
    endfunction

    // Staged registers and the live copy
    logic [6:0]     feedback_q;
    logic [1:0]     prescale_q;
    logic           source_q;
    logic [2:0]     refout_q;
    logic           enable_q;
    sck_settings_t  active_q;
    sck_state_t     state_q;
    sck_state_t     state_d;
    logic           lock_q;
    logic [1:0]     irq_stat_q;
    logic [1:0]     irq_mask_q;
    logic           irq_q;

    // Bus slave state
    logic              aw_have_q;
    logic [IDX_W-1:0]  aw_idx_q;
    logic              w_have_q;
    logic [31:0]       w_data_q;
    logic [3:0]        w_strb_q;
    logic              awready_q;
    logic              wready_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              arready_q;
    logic              rvalid_q;
    logic [31:0]       rdata_q;
    logic [1:0]        rresp_q;

    // Input clock path
    logic              mclk_s1_q;
    logic              mclk_s2_q;
    logic              mclk_s3_q;
    logic [2:0]        pre_cnt_q;
    logic [7:0]        edge_cnt_q;
    logic [15:0]       gap_cnt_q;
    logic [15:0]       period_q;
    logic [15:0]       out_cnt_q;
    logic              ref_q;
    logic              oe_q;
    logic              running_q;

    // Write channel handshakes and commit
    wire aw_take = s_axi_awvalid_in & awready_q;
    wire w_take  = s_axi_wvalid_in & wready_q;
    wire commit  = aw_have_q & w_have_q & ~bvalid_q;
    wire aw_have_d = commit ? 1'b0 : (aw_have_q | aw_take);
    wire w_have_d  = commit ? 1'b0 : (w_have_q | w_take);
    wire bvalid_d  = commit | (bvalid_q & ~s_axi_bready_in);

    wire wr_feedback = commit && (aw_idx_q == `SCK_IDX_FEEDBACK);
    wire wr_prescale = commit && (aw_idx_q == `SCK_IDX_PRESCALE);
    wire wr_source   = commit && (aw_idx_q == `SCK_IDX_SOURCE);
    wire wr_enable   = commit && (aw_idx_q == `SCK_IDX_ENABLE);
    wire wr_lock     = commit && (aw_idx_q == `SCK_IDX_LOCK);
    wire wr_refout   = commit && (aw_idx_q == `SCK_IDX_REFOUT);
    wire wr_irq_stat = commit && (aw_idx_q == `SCK_IDX_IRQ_STAT);
    wire wr_irq_mask = commit && (aw_idx_q == `SCK_IDX_IRQ_MASK);
    wire wr_hit = wr_feedback | wr_prescale | wr_source | wr_enable | wr_lock | wr_refout | wr_irq_stat
                | wr_irq_mask;

    wire [15:0] wr_val_feedback = merge16({9'h000, feedback_q}, w_data_q, w_strb_q);
    wire [15:0] wr_val_prescale = merge16({14'h0000, prescale_q}, w_data_q, w_strb_q);
    wire [15:0] wr_val_source   = merge16({15'h0000, source_q}, w_data_q, w_strb_q);
    wire [15:0] wr_val_enable   = merge16({15'h0000, enable_q}, w_data_q, w_strb_q);
    wire [15:0] wr_val_refout   = merge16({13'h0000, refout_q}, w_data_q, w_strb_q);
    wire [15:0] wr_val_mask     = merge16({14'h0000, irq_mask_q}, w_data_q, w_strb_q);

    // Enable rising edge loads the staged settings
    wire enable_d = wr_enable ? wr_val_enable[0] : enable_q;
    wire load     = wr_enable & wr_val_enable[0] & ~enable_q;
    sck_settings_t staged;
    assign staged = '{feedback: feedback_q, prescale: prescale_q, source: source_q,
                      out_rate: refout_q[`SCK_REFOUT_RATE_HI:`SCK_REFOUT_RATE_LO],
                      out_en: refout_q[`SCK_REFOUT_EN_BIT]};

    // Read channel
    wire ar_take = s_axi_arvalid_in & arready_q;
    wire rvalid_d = ar_take | (rvalid_q & ~s_axi_rready_in);
    wire [IDX_W-1:0] ar_idx = s_axi_araddr_in[ADDR_W-1:2];
    wire rd_feedback = (ar_idx == `SCK_IDX_FEEDBACK);
    wire rd_prescale = (ar_idx == `SCK_IDX_PRESCALE);
    wire rd_source   = (ar_idx == `SCK_IDX_SOURCE);
    wire rd_enable   = (ar_idx == `SCK_IDX_ENABLE);
    wire rd_lock     = (ar_idx == `SCK_IDX_LOCK);
    wire rd_refout   = (ar_idx == `SCK_IDX_REFOUT);
    wire rd_irq_stat = (ar_idx == `SCK_IDX_IRQ_STAT);
    wire rd_irq_mask = (ar_idx == `SCK_IDX_IRQ_MASK);
    wire rd_hit = rd_feedback | rd_prescale | rd_source | rd_enable | rd_lock | rd_refout | rd_irq_stat
                | rd_irq_mask;
    logic [15:0] rd_val;
    assign rd_val = rd_feedback ? {9'h000, feedback_q} :
                    rd_prescale ? {14'h0000, prescale_q} :
                    rd_source   ? {15'h0000, source_q} :
                    rd_enable   ? {15'h0000, enable_q} :
                    rd_lock     ? {15'h0000, lock_q} :
                    rd_refout   ? {13'h0000, refout_q} :
                    rd_irq_stat ? {14'h0000, irq_stat_q} :
                    rd_irq_mask ? {14'h0000, irq_mask_q} : 16'h0000;

    // Prescaler on the synchronised master clock
    wire mclk_rise = mclk_s2_q & ~mclk_s3_q;
    logic [2:0] div_mask;
    assign div_mask = (active_q.prescale == 2'b00) ? 3'h0 :
                      (active_q.prescale == 2'b01) ? 3'h1 :
                      (active_q.prescale == 2'b10) ? 3'h3 : 3'h7;
    wire acquiring = (state_q != SCK_IDLE);
    wire pre_tick  = acquiring & mclk_rise & ((pre_cnt_q & div_mask) == div_mask);
    wire gap_out   = (gap_cnt_q == 16'(GAP_CYC - 1));
    wire settings_ok = (active_q.feedback != 7'h00);

    // Lock sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            SCK_IDLE: begin
                if (enable_q && settings_ok && !load) begin
                    state_d = SCK_ACQUIRE;
                end
            end
            SCK_ACQUIRE: begin
                if (!enable_q || load) begin
                    state_d = SCK_IDLE;
                end else if (pre_tick && edge_cnt_q == 8'(LOCK_EDGES - 1)) begin
                    state_d = SCK_LOCKED;
                end
            end
            SCK_LOCKED: begin
                if (!enable_q || load) begin
                    state_d = SCK_IDLE;
                end else if (gap_out) begin
                    state_d = SCK_ACQUIRE;
                end
            end
            default: begin
                state_d = SCK_IDLE;
            end
        endcase
    end

    wire ev_locked = (state_q != SCK_LOCKED) & (state_d == SCK_LOCKED);
    wire ev_lost   = (state_q == SCK_LOCKED) & (state_d == SCK_ACQUIRE);
    wire [1:0] irq_ev = {ev_lost, ev_locked};
    wire [1:0] irq_clr = (ar_take && rd_irq_stat) ? 2'b11 : 2'b00;
    // A new event in the clearing cycle stays set
    wire [1:0] irq_stat_d = (irq_stat_q & ~irq_clr) | irq_ev;

    // Reference output half period from the measured predivider period
    wire [15:0] half_raw = period_q >> ({1'b0, active_q.out_rate} + 3'd1);
    wire [15:0] half     = (half_raw == 16'h0000) ? 16'h0001 : half_raw;
    wire running = (state_q == SCK_LOCKED);

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q  <= w_have_d;
            awready_q <= ~aw_have_d & ~bvalid_d;
            wready_q  <= ~w_have_d & ~bvalid_d;
            bvalid_q  <= bvalid_d;
            arready_q <= ~rvalid_d;
            rvalid_q  <= rvalid_d;
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            aw_idx_q <= '0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            bresp_q  <= 2'b00;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= 2'b00;
        end else begin
            if (aw_take) begin
                aw_idx_q <= s_axi_awaddr_in[ADDR_W-1:2];
            end
            if (w_take) begin
                w_data_q <= s_axi_wdata_in;
                w_strb_q <= s_axi_wstrb_in;
            end
            if (commit) begin
                bresp_q <= wr_hit ? 2'b00 : 2'b10;
            end
            if (ar_take) begin
                rdata_q <= {16'h0000, rd_val};
                rresp_q <= rd_hit ? 2'b00 : 2'b10;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            feedback_q <= `SCK_RST_FEEDBACK;
            prescale_q <= `SCK_RST_PRESCALE;
            source_q   <= `SCK_RST_SOURCE;
            refout_q   <= `SCK_RST_REFOUT;
            enable_q   <= `SCK_RST_ENABLE;
            irq_mask_q <= 2'h0;
        end else begin
            if (wr_feedback) begin
                feedback_q <= wr_val_feedback[6:0];
            end
            if (wr_prescale) begin
                prescale_q <= wr_val_prescale[1:0];
            end
            if (wr_source) begin
                source_q <= wr_val_source[0];
            end
            if (wr_refout) begin
                refout_q <= wr_val_refout[2:0];
            end
            if (wr_irq_mask) begin
                irq_mask_q <= wr_val_mask[1:0];
            end
            enable_q <= enable_d;
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            active_q   <= '{feedback: `SCK_RST_FEEDBACK, prescale: `SCK_RST_PRESCALE, source: `SCK_RST_SOURCE,
                            out_rate: 2'b00, out_en: 1'b0};
            state_q    <= SCK_IDLE;
            lock_q     <= 1'b0;
            irq_stat_q <= 2'h0;
            irq_q      <= 1'b0;
        end else begin
            if (load) begin
                active_q <= staged;
            end
            state_q    <= state_d;
            lock_q     <= (state_d == SCK_LOCKED);
            irq_stat_q <= irq_stat_d;
            irq_q      <= |(irq_stat_q & irq_mask_q);
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mclk_s1_q <= 1'b0;
            mclk_s2_q <= 1'b0;
            mclk_s3_q <= 1'b0;
        end else begin
            mclk_s1_q <= master_clock_pin_in;
            mclk_s2_q <= mclk_s1_q;
            mclk_s3_q <= mclk_s2_q;
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pre_cnt_q  <= 3'h0;
            edge_cnt_q <= 8'h00;
            gap_cnt_q  <= 16'h0000;
            period_q   <= 16'h0000;
        end else if (!acquiring || load) begin
            pre_cnt_q  <= 3'h0;
            edge_cnt_q <= 8'h00;
            gap_cnt_q  <= 16'h0000;
        end else begin
            if (mclk_rise) begin
                pre_cnt_q <= pre_cnt_q + 3'h1;
            end
            if (pre_tick) begin
                period_q   <= gap_cnt_q + 16'h0001;
                gap_cnt_q  <= 16'h0000;
                edge_cnt_q <= (state_q == SCK_ACQUIRE) ? edge_cnt_q + 8'h01 : edge_cnt_q;
            end else if (gap_out) begin
                // Input clock stopped: restart settling count
                gap_cnt_q  <= 16'h0000;
                edge_cnt_q <= 8'h00;
            end else begin
                gap_cnt_q <= gap_cnt_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            out_cnt_q <= 16'h0000;
            ref_q     <= 1'b0;
            oe_q      <= 1'b0;
            running_q <= 1'b0;
        end else begin
            oe_q      <= active_q.out_en;
            running_q <= running;
            if (!running) begin
                out_cnt_q <= 16'h0000;
                ref_q     <= 1'b0;
            end else if (out_cnt_q + 16'h0001 >= half) begin
                out_cnt_q <= 16'h0000;
                ref_q     <= ~ref_q;
            end else begin
                out_cnt_q <= out_cnt_q + 16'h0001;
            end
        end
    end

    assign s_axi_awready_out        = awready_q;
    assign s_axi_wready_out         = wready_q;
    assign s_axi_bvalid_out         = bvalid_q;
    assign s_axi_bresp_out          = bresp_q;
    assign s_axi_arready_out        = arready_q;
    assign s_axi_rvalid_out         = rvalid_q;
    assign s_axi_rdata_out          = rdata_q;
    assign s_axi_rresp_out          = rresp_q;
    assign ref_output_pin_out       = ref_q;
    assign ref_output_pin_oe_out    = oe_q;
    assign synth_clock_running_out  = running_q;
    assign core_clock_source_bit_out = active_q.source;
    assign synth_settings_out       = active_q;
    assign irq_out                  = irq_q;

endmodule
`default_nettype wire

// ---- bench/sck_ctrl_props.sv ----
// Port-level assertions for the synthesizer control block.
// Assumes one clock domain; bound to sck_ctrl_top below.
`timescale 1ns/1ps
`default_nettype none
module sck_ctrl_props #(
    parameter int ADDR_W     = 18,
    parameter int LOCK_EDGES = 64,
    parameter int GAP_CYC    = 200
) (
    input wire logic                   sys_clk_in,
    input wire logic                   resetn_in,
    input wire logic                   s_axi_awvalid_in,
    input wire logic                   s_axi_awready_out,
    input wire logic                   s_axi_wvalid_in,
    input wire logic                   s_axi_wready_out,
    input wire logic                   s_axi_bvalid_out,
    input wire logic                   s_axi_bready_in,
    input wire logic                   s_axi_arvalid_in,
    input wire logic                   s_axi_arready_out,
    input wire logic [31:0]            s_axi_rdata_out,
    input wire logic                   s_axi_rvalid_out,
    input wire logic                   s_axi_rready_in,
    input wire logic                   ref_output_pin_out,
    input wire logic                   ref_output_pin_oe_out,
    input wire logic                   synth_clock_running_out,
    input wire logic                   core_clock_source_bit_out,
    input wire sck_pkg::sck_settings_t synth_settings_out
);
    import sck_pkg::*;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    sequence s_wr_taken;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
    endsequence
    sequence s_load;
        $changed(synth_settings_out);
    endsequence
    a_wr_resp_next: assert property (s_wr_taken |-> ##2 s_axi_bvalid_out) else $error("write answer late");
    a_rd_resp_next: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("read answer late");
    a_rd_data_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read data dropped");
    a_load_on_commit: assert property (s_load |-> $rose(s_axi_bvalid_out)) else $error("settings moved off commit");
    a_reload_clears_lock: assert property (s_load |-> ##[1:2] !synth_clock_running_out)
        else $error("lock kept over reload");
    a_pin_quiet_unlocked: assert property (!synth_clock_running_out [*2] |-> !ref_output_pin_out)
        else $error("pin toggles unlocked");
    a_oe_tracks_en: assert property (synth_settings_out.out_en [*2] |-> ref_output_pin_oe_out)
        else $error("pin not driven");
    a_oe_needs_en: assert property (ref_output_pin_oe_out |-> synth_settings_out.out_en || $past(synth_settings_out.out_en))
        else $error("pin driven while disabled");
    a_source_live: assert property ($changed(core_clock_source_bit_out) |-> $rose(s_axi_bvalid_out))
        else $error("source bit moved off commit");
    a_lock_valid_fb: assert property (synth_clock_running_out |-> synth_settings_out.feedback != 7'h00)
        else $error("lock with zero feedback");
endmodule
bind sck_ctrl_top sck_ctrl_props #(.ADDR_W(ADDR_W), .LOCK_EDGES(LOCK_EDGES), .GAP_CYC(GAP_CYC)) u_props (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .s_axi_awvalid_in(s_axi_awvalid_in),
    .s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
    .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in), .s_axi_arvalid_in(s_axi_arvalid_in),
    .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rvalid_out(s_axi_rvalid_out),
    .s_axi_rready_in(s_axi_rready_in), .ref_output_pin_out(ref_output_pin_out),
    .ref_output_pin_oe_out(ref_output_pin_oe_out), .synth_clock_running_out(synth_clock_running_out),
    .core_clock_source_bit_out(core_clock_source_bit_out), .synth_settings_out(synth_settings_out));
`default_nettype wire

// ---- bench/sck_ctrl_tb_top.sv ----
// Self-checking bench for the synthesizer control block.
// Assumes AXI4-Lite access with byte address = 4 * register index.
`timescale 1ns/1ps
`default_nettype none
`include "sck_ctrl_regs.svh"
module sck_ctrl_tb_top;
    import sck_pkg::*;
    logic          clk = 0, rst_n = 0, mclk = 0, mclk_run = 1;
    logic [17:0]   awaddr = '0, araddr = '0;
    logic          awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0]   wdata = '0, rdata, rd;
    logic          awready, wready, bvalid, arready, rvalid, pin, oe, running, src, irq, p;
    logic [1:0]    bresp, rresp, rsp;
    sck_settings_t set;
    int            fail_count = 0, check_count = 0, n, e;
    logic [15:0]   idx_tab [6] = '{`SCK_IDX_FEEDBACK, `SCK_IDX_PRESCALE, `SCK_IDX_SOURCE,
                                   `SCK_IDX_ENABLE, `SCK_IDX_LOCK, `SCK_IDX_REFOUT};
    logic [31:0]   exp_tab [6] = '{32'h60, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

    sck_ctrl_top #(.ADDR_W(18), .LOCK_EDGES(4), .GAP_CYC(100)) dut (
        .sys_clk_in(clk), .resetn_in(rst_n), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .master_clock_pin_in(mclk), .ref_output_pin_out(pin), .ref_output_pin_oe_out(oe),
        .synth_clock_running_out(running), .core_clock_source_bit_out(src), .synth_settings_out(set),
        .irq_out(irq));

    initial forever #5 clk = ~clk;
    // Master clock: 8 system cycles per period, before the prescale
    initial forever begin
        repeat (4) @(posedge clk);
        if (mclk_run) mclk <= ~mclk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] idx, input logic [15:0] d);
        awaddr <= {idx, 2'b00};
        wdata <= {16'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        rsp = bresp;
        @(posedge clk);
    endtask

    task automatic rd_reg(input logic [15:0] idx);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        rd = rdata;
        rsp = rresp;
        @(posedge clk);
    endtask

    task automatic rchk(input string nm, input logic [15:0] idx, input logic [31:0] exp);
        rd_reg(idx);
        chk(nm, rd, exp);
    endtask

    // Software polls the flag with no fixed lock time assumed
    task automatic wait_lock;
        n = 0;
        do begin
            rd_reg(`SCK_IDX_LOCK);
            n++;
        end while (rd !== 32'h1 && n < 200);
        chk("lock_flag", rd, 32'h1);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        fail_count++;
        tally_and_finish();
    end

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (idx_tab[i]) rchk("reset_value", idx_tab[i], exp_tab[i]);
        chk("reset_oe", oe, 1'b0);
        chk("reset_settings", set, 13'h1800);
        // Read answer held back by a late rready
        araddr <= {`SCK_IDX_FEEDBACK, 2'b00};
        arvalid <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        rready <= 1'b1;
        @(posedge clk);
        chk("held_rdata", rdata, 32'h60);
        rready <= 1'b0;
        @(posedge clk);
        wr(`SCK_IDX_LOCK, 16'h1);
        rchk("lock_ro", `SCK_IDX_LOCK, 32'h0);
        rd_reg(16'h0123);
        chk("unmapped_rresp", rsp, 2'b10);
        wr(16'h0123, 16'h1);
        chk("unmapped_bresp", rsp, 2'b10);
        repeat (100) @(posedge clk);
        chk("idle_no_lock", running, 1'b0);
        wr(`SCK_IDX_PRESCALE, 16'h1);
        wr(`SCK_IDX_SOURCE, 16'h1);
        wr(`SCK_IDX_REFOUT, 16'h1);
        chk("staged_settings", set, 13'h1800);
        chk("staged_oe", oe, 1'b0);
        chk("staged_src", src, 1'b0);
        for (int r = 0; r < 4; r++) begin
            wr(`SCK_IDX_PRESCALE, 16'(r ^ 1));
            wr(`SCK_IDX_REFOUT, 16'(r * 2 + 1));
            wr(`SCK_IDX_ENABLE, 16'h1);
            chk("live_settings", set, {7'h60, 2'(r ^ 1), 1'b1, r[1:0], 1'b1});
            chk("core_src", src, 1'b1);
            wait_lock();
            chk("oe_on", oe, 1'b1);
            n = 0;
            p = pin;
            repeat (256) begin
                @(posedge clk);
                if (pin !== p) n++;
                p = pin;
            end
            e = (64 << r) >> (r ^ 1);
            chk("rate_toggles", n >= e - 3 && n <= e + 3, 1'b1);
            wr(`SCK_IDX_ENABLE, 16'h0);
            @(posedge clk);
            chk("off_running", running, 1'b0);
            rchk("off_lock", `SCK_IDX_LOCK, 32'h0);
        end
        wr(`SCK_IDX_REFOUT, 16'h0);
        wr(`SCK_IDX_ENABLE, 16'h1);
        wait_lock();
        chk("oe_off", oe, 1'b0);
        chk("irq_masked", irq, 1'b0);
        wr(`SCK_IDX_IRQ_MASK, 16'h1);
        repeat (3) @(posedge clk);
        chk("irq_on", irq, 1'b1);
        rchk("irq_stat_lock", `SCK_IDX_IRQ_STAT, 32'h1);
        repeat (3) @(posedge clk);
        chk("irq_cleared", irq, 1'b0);
        mclk_run <= 1'b0;
        repeat (160) @(posedge clk);
        chk("gap_unlock", running, 1'b0);
        rchk("irq_stat_lost", `SCK_IDX_IRQ_STAT, 32'h2);
        chk("irq_lost_masked", irq, 1'b0);
        mclk_run <= 1'b1;
        wr(`SCK_IDX_ENABLE, 16'h0);
        wr(`SCK_IDX_FEEDBACK, 16'h0);
        wr(`SCK_IDX_ENABLE, 16'h1);
        repeat (200) @(posedge clk);
        chk("bad_fb_no_lock", running, 1'b0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
